// ---- logic/cbsc_exec.sv ----
// Purpose: executes pop, stack pointer, branch, bit branch, loop and cpu control instructions
// Assumes: data memory answers a read on the cycle after memRe; clk is the cpu clock
// Notes: one instruction at a time; start is ignored while busy or in a standby mode
module cbsc_exec
  import cbsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction request
  input wire logic start,
  input wire cbsc_op_t opSel,
  input wire cbsc_bit_kind_t bitKind,
  input wire logic [2:0] bitSel,
  input wire logic [1:0] pairSel,
  input wire logic [15:0] opAddr,
  input wire logic [15:0] immWord,
  input wire logic areaSlow,
  output logic busy,
  output logic done,
  // register pairs read from the register file
  input wire logic [15:0] accPair,
  input wire logic [15:0] bcPair,
  input wire logic [15:0] hlPair,
  // register file write port
  output logic regWrEn,
  output logic [1:0] regWrPair,
  output logic [1:0] regWrMask,
  output logic [15:0] regWrData,
  // data memory
  output logic memRe,
  output logic memWe,
  output logic [15:0] memAddr,
  output logic [7:0] memWrData,
  input wire logic [7:0] memRdData,
  // cpu state
  output logic [15:0] pc,
  output logic [15:0] sp,
  output logic [7:0] programStatusWord,
  output logic haltMode,
  output logic stopMode,
  input wire logic wakePin
);

  cbsc_op_t op;
  cbsc_bit_kind_t kind;
  logic [2:0] bitIdx;
  logic [1:0] pair;
  logic [15:0] imm;
  logic slow;
  logic [3:0] cnt;
  logic [7:0] data0;
  logic wakeMeta;
  logic wakeSync;

  // decode of the held instruction
  wire logic [3:0] lastCnt = cbsc_clocks(op, kind, slow) - 4'h1;
  wire logic atLast = busy && (cnt == lastCnt);
  wire logic preLast = busy && (cnt == lastCnt - 4'h1);
  wire logic memKind = (kind == BIT_SHORT_DIRECT) || (kind == BIT_SFR) || (kind == BIT_INDIRECT);
  wire logic bitOp = (op == OP_JUMP_IF_BIT_SET) || (op == OP_JUMP_IF_BIT_CLEAR)
                     || (op == OP_JUMP_AND_CLEAR_BIT);
  wire logic [7:0] byte0Now = (cnt == 4'h1) ? memRdData : data0;
  wire logic [7:0] accHigh = accPair[15:8];
  wire logic [7:0] bitByte = (kind == BIT_ACC) ? accHigh
                           : (kind == BIT_PSW) ? programStatusWord : data0;
  wire logic bitNow = bitByte[bitIdx];
  wire logic [7:0] bitMask = 8'h01 << bitIdx;
  wire logic [7:0] decSrc = (op == OP_DEC_JUMP_B) ? bcPair[15:8]
                          : (op == OP_DEC_JUMP_C) ? bcPair[7:0] : data0;
  wire logic [7:0] decVal = decSrc - 8'h01;
  wire logic clearHit = (op == OP_JUMP_AND_CLEAR_BIT) && bitNow;

  // start side decode
  wire logic accept = start && !busy && !haltMode && !stopMode;
  wire logic startMemKind = (bitKind == BIT_SHORT_DIRECT) || (bitKind == BIT_SFR)
                            || (bitKind == BIT_INDIRECT);
  wire logic startBitOp = (opSel == OP_JUMP_IF_BIT_SET) || (opSel == OP_JUMP_IF_BIT_CLEAR)
                          || (opSel == OP_JUMP_AND_CLEAR_BIT);
  wire logic startRead = (opSel == OP_POP_PSW) || (opSel == OP_POP_PAIR)
                         || (opSel == OP_DEC_JUMP_MEM) || (startBitOp && startMemKind);
  wire logic [15:0] startAddr = ((opSel == OP_POP_PSW) || (opSel == OP_POP_PAIR)) ? sp
                              : (bitKind == BIT_INDIRECT && startBitOp) ? hlPair : opAddr;

  // branch arithmetic
  logic [15:0] fallThrough;
  logic [15:0] target;
  cbsc_target u_target (
    .pcNow(pc),
    .instrLen(cbsc_length(op, kind)),
    .offset(imm[7:0]),
    .fallThrough(fallThrough),
    .target(target)
  );

  // branch decision per instruction
  logic taken;
  always_comb begin
    unique case (op)
      OP_JUMP_ALWAYS: taken = 1'b1;
      OP_JUMP_IF_CARRY: taken = programStatusWord[PSW_CARRY];
      OP_JUMP_IF_NO_CARRY: taken = !programStatusWord[PSW_CARRY];
      OP_JUMP_IF_ZERO: taken = programStatusWord[PSW_ZERO];
      OP_JUMP_IF_NONZERO: taken = !programStatusWord[PSW_ZERO];
      OP_JUMP_IF_BIT_SET, OP_JUMP_AND_CLEAR_BIT: taken = bitNow;
      OP_JUMP_IF_BIT_CLEAR: taken = !bitNow;
      OP_DEC_JUMP_B, OP_DEC_JUMP_C, OP_DEC_JUMP_MEM: taken = (decVal != 8'h00);
      default: taken = 1'b0;
    endcase
  end

  // architectural state updates, all applied on the final clock
  logic [15:0] next_pc;
  logic [15:0] next_sp;
  logic [7:0] next_psw;
  always_comb begin
    next_pc = pc;
    next_sp = sp;
    next_psw = programStatusWord;
    if (atLast) begin
      unique case (op)
        OP_JUMP_ABS: next_pc = imm;
        OP_JUMP_ACC: next_pc = accPair;
        default: next_pc = taken ? target : fallThrough;
      endcase
      unique case (op)
        OP_POP_PSW: next_sp = sp + 16'h0001;
        OP_POP_PAIR: next_sp = sp + 16'h0002;
        OP_SP_LOAD_IMM: next_sp = imm;
        OP_SP_LOAD_ACC: next_sp = accPair;
        default: next_sp = sp;
      endcase
      unique case (op)
        OP_POP_PSW: next_psw = byte0Now;
        OP_IRQ_ENABLE: next_psw[PSW_IE] = 1'b1;
        OP_IRQ_DISABLE: next_psw[PSW_IE] = 1'b0;
        OP_BANK_SELECT: begin
          next_psw[PSW_BANK1] = imm[1];
          next_psw[PSW_BANK0] = imm[0];
        end
        // clearing a status bit may drop zero, aux carry or carry
        OP_JUMP_AND_CLEAR_BIT: if (kind == BIT_PSW && clearHit) begin
          next_psw = programStatusWord & ~bitMask;
        end
        default: next_psw = programStatusWord;
      endcase
    end
  end

  // write-backs are staged one clock early so they land inside the instruction
  logic next_regWrEn;
  logic [1:0] next_regWrPair;
  logic [1:0] next_regWrMask;
  logic [15:0] next_regWrData;
  logic next_memWe;
  logic [7:0] next_memWrData;
  always_comb begin
    next_regWrEn = 1'b0;
    next_regWrPair = PAIR_ACC;
    next_regWrMask = 2'h3;
    next_regWrData = 16'h0000;
    next_memWe = 1'b0;
    next_memWrData = 8'h00;
    if (preLast) begin
      unique case (op)
        OP_POP_PAIR: begin
          next_regWrEn = 1'b1;
          next_regWrPair = pair;
          next_regWrData = {memRdData, data0};
        end
        OP_ACC_LOAD_SP: begin
          next_regWrEn = 1'b1;
          next_regWrData = sp;
        end
        OP_DEC_JUMP_B: begin
          next_regWrEn = 1'b1;
          next_regWrPair = PAIR_BC;
          next_regWrMask = 2'h2;
          next_regWrData = {decVal, 8'h00};
        end
        OP_DEC_JUMP_C: begin
          next_regWrEn = 1'b1;
          next_regWrPair = PAIR_BC;
          next_regWrMask = 2'h1;
          next_regWrData = {8'h00, decVal};
        end
        OP_DEC_JUMP_MEM: begin
          next_memWe = 1'b1;
          next_memWrData = decVal;
        end
        OP_JUMP_AND_CLEAR_BIT: begin
          next_regWrEn = clearHit && (kind == BIT_ACC);
          next_regWrMask = 2'h2;
          next_regWrData = {accHigh & ~bitMask, 8'h00};
          next_memWe = clearHit && memKind;
          next_memWrData = data0 & ~bitMask;
        end
        default: next_regWrEn = 1'b0;
      endcase
    end
  end

  // reads: first byte issued with the start, pair pop asks sp+1 one clock later
  wire logic next_memRe = (accept && startRead) || (busy && cnt == 4'h0 && op == OP_POP_PAIR);
  wire logic [15:0] next_memAddr = accept ? startAddr
                                 : (busy && cnt == 4'h0 && op == OP_POP_PAIR) ? sp + 16'h0001
                                 : memAddr;

  assign done = atLast;

  // wake pin is asynchronous to clk
  always_ff @(posedge clk) begin
    wakeMeta <= rst ? 1'b0 : wakePin;
    wakeSync <= rst ? 1'b0 : wakeMeta;
  end

  // sequencing and held instruction fields
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      op <= OP_NOP;
      kind <= BIT_SHORT_DIRECT;
      bitIdx <= 3'h0;
      pair <= PAIR_ACC;
      imm <= 16'h0000;
      slow <= 1'b0;
      data0 <= 8'h00;
    end else begin
      if (accept) begin
        busy <= 1'b1;
        cnt <= 4'h0;
        op <= opSel;
        kind <= bitKind;
        bitIdx <= bitSel;
        pair <= pairSel;
        imm <= immWord;
        slow <= areaSlow;
      end else if (atLast) begin
        busy <= 1'b0;
      end else if (busy) begin
        cnt <= cnt + 4'h1;
      end
      if (busy && cnt == 4'h1) begin
        data0 <= memRdData;
      end
    end
  end

  // cpu state, standby modes and bus outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      pc <= PC_RESET;
      sp <= SP_RESET;
      programStatusWord <= PSW_RESET;
      haltMode <= 1'b0;
      stopMode <= 1'b0;
      memRe <= 1'b0;
      memWe <= 1'b0;
      memAddr <= 16'h0000;
      memWrData <= 8'h00;
      regWrEn <= 1'b0;
      regWrPair <= PAIR_ACC;
      regWrMask <= 2'h0;
      regWrData <= 16'h0000;
    end else begin
      pc <= next_pc;
      sp <= next_sp;
      programStatusWord <= next_psw;
      // entry on the final clock wins over a wake in the same cycle
      haltMode <= (atLast && op == OP_HALT) || (haltMode && !wakeSync);
      stopMode <= (atLast && op == OP_STOP) || (stopMode && !wakeSync);
      memRe <= next_memRe;
      memWe <= next_memWe;
      memAddr <= next_memAddr;
      memWrData <= next_memWrData;
      regWrEn <= next_regWrEn;
      regWrPair <= next_regWrPair;
      regWrMask <= next_regWrMask;
      regWrData <= next_regWrData;
    end
  end

endmodule // cbsc_exec

// ---- logic/cbsc_pkg.sv ----
// Purpose: shared constants, types and timing tables for the branch and stack control unit
// Assumes: clk is the cpu clock picked by the clock select setting; code runs from internal rom
// Notes: cycle counts below are whole instruction clocks, first column for fast ram
//
// Contract
// - pair pop: high sp+1, low sp, sp+=2
// - relative jump: pc+2+offset, six clocks
// - carry jumps follow carry flag, six clocks
// - zero jumps follow zero flag, six clocks
// - short direct bit set jump: pc+3, 8/9 clocks
// - sfr bit set jump: four bytes, eleven clocks
// - bit clear jump on zero; acc form 3 bytes
// - indirect test-and-clear branches and clears, 10/12 clocks
// - status word test-and-clear may change flags, 12 clocks
// - loop register decrement then jump if nonzero, 6
// - memory byte decrement, jump from pc+3, 8/10
// - irq enable op sets enable flag, six clocks
// - irq disable op clears enable flag, six clocks
// - one counted clock is one cpu clock period
// - counts assume fetch from internal program memory
// - second count column for areas outside fast ram
package cbsc_pkg;

  typedef enum logic [4:0] {
    OP_NOP, OP_POP_PSW, OP_POP_PAIR, OP_SP_LOAD_IMM, OP_SP_LOAD_ACC, OP_ACC_LOAD_SP,
    OP_JUMP_ABS, OP_JUMP_ALWAYS, OP_JUMP_ACC, OP_JUMP_IF_CARRY, OP_JUMP_IF_NO_CARRY,
    OP_JUMP_IF_ZERO, OP_JUMP_IF_NONZERO, OP_JUMP_IF_BIT_SET, OP_JUMP_IF_BIT_CLEAR,
    OP_JUMP_AND_CLEAR_BIT, OP_DEC_JUMP_B, OP_DEC_JUMP_C, OP_DEC_JUMP_MEM,
    OP_BANK_SELECT, OP_IRQ_ENABLE, OP_IRQ_DISABLE, OP_HALT, OP_STOP
  } cbsc_op_t;

  typedef enum logic [2:0] {
    BIT_SHORT_DIRECT, BIT_SFR, BIT_ACC, BIT_PSW, BIT_INDIRECT
  } cbsc_bit_kind_t;

  // register pair indices on the write port
  localparam logic [1:0] PAIR_ACC = 2'h0;
  localparam logic [1:0] PAIR_BC = 2'h1;
  localparam logic [1:0] PAIR_DE = 2'h2;
  localparam logic [1:0] PAIR_HL = 2'h3;

  // program status word bit positions
  localparam int PSW_IE = 7;
  localparam int PSW_ZERO = 6;
  localparam int PSW_BANK1 = 5;
  localparam int PSW_AUX = 4;
  localparam int PSW_BANK0 = 3;
  localparam int PSW_CARRY = 0;

  // values after reset
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [7:0] PSW_RESET = 8'h02;

  // instruction clock counts
  localparam logic [3:0] CLK_2 = 4'h2;
  localparam logic [3:0] CLK_4 = 4'h4;
  localparam logic [3:0] CLK_6 = 4'h6;
  localparam logic [3:0] CLK_8 = 4'h8;
  localparam logic [3:0] CLK_9 = 4'h9;
  localparam logic [3:0] CLK_10 = 4'ha;
  localparam logic [3:0] CLK_11 = 4'hb;
  localparam logic [3:0] CLK_12 = 4'hc;

  // instruction lengths in bytes
  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_3 = 3'h3;
  localparam logic [2:0] LEN_4 = 3'h4;

  // clocks per instruction; slow picks the outside-fast-ram column
  function automatic logic [3:0] cbsc_clocks(cbsc_op_t op, cbsc_bit_kind_t kind, logic slow);
    logic [3:0] c;
    c = CLK_6;
    unique case (op)
      OP_NOP, OP_POP_PSW: c = CLK_2;
      OP_POP_PAIR, OP_BANK_SELECT: c = CLK_4;
      OP_SP_LOAD_IMM: c = CLK_10;
      OP_SP_LOAD_ACC, OP_ACC_LOAD_SP, OP_JUMP_ACC: c = CLK_8;
      OP_JUMP_IF_BIT_SET: unique case (kind)
        BIT_SHORT_DIRECT: c = slow ? CLK_9 : CLK_8;
        BIT_SFR: c = CLK_11;
        BIT_ACC: c = CLK_8;
        BIT_PSW: c = CLK_9;
        default: c = slow ? CLK_11 : CLK_10;
      endcase
      OP_JUMP_IF_BIT_CLEAR: unique case (kind)
        BIT_SFR, BIT_PSW: c = CLK_11;
        BIT_ACC: c = CLK_8;
        default: c = slow ? CLK_11 : CLK_10;
      endcase
      OP_JUMP_AND_CLEAR_BIT: unique case (kind)
        BIT_SFR, BIT_PSW: c = CLK_12;
        BIT_ACC: c = CLK_8;
        default: c = slow ? CLK_12 : CLK_10;
      endcase
      OP_DEC_JUMP_MEM: c = slow ? CLK_10 : CLK_8;
      default: c = CLK_6;
    endcase
    return c;
  endfunction

  // byte length of each instruction form
  function automatic logic [2:0] cbsc_length(cbsc_op_t op, cbsc_bit_kind_t kind);
    logic [2:0] n;
    n = LEN_2;
    unique case (op)
      OP_NOP, OP_POP_PSW, OP_POP_PAIR: n = LEN_1;
      OP_SP_LOAD_IMM: n = LEN_4;
      OP_JUMP_ABS, OP_DEC_JUMP_MEM: n = LEN_3;
      OP_JUMP_IF_BIT_SET, OP_JUMP_IF_BIT_CLEAR, OP_JUMP_AND_CLEAR_BIT: unique case (kind)
        BIT_ACC, BIT_INDIRECT: n = LEN_3;
        BIT_SFR: n = LEN_4;
        default: n = (op == OP_JUMP_IF_BIT_SET) ? LEN_3 : LEN_4;
      endcase
      default: n = LEN_2;
    endcase
    return n;
  endfunction

endpackage

// ---- logic/cbsc_target.sv ----
// Purpose: relative branch target and fall-through address
// Assumes: offset is two's complement
// Notes: pure combinational adder shared by every relative form
module cbsc_target
  import cbsc_pkg::*;
(
  // address of the current instruction and its length
  input wire logic [15:0] pcNow,
  input wire logic [2:0] instrLen,
  input wire logic [7:0] offset,
  // results
  output logic [15:0] fallThrough,
  output logic [15:0] target
);

  // offset is sign extended and added to the next instruction's address
  assign fallThrough = pcNow + {13'h0000, instrLen};
  assign target = fallThrough + {{8{offset[7]}}, offset};

endmodule // cbsc_target

// ---- verification/cbsc_exec_props.sv ----
// Purpose: concurrent checks on the branch and stack control unit ports
// Assumes: one clock domain, synchronous active high reset
// Notes: operands are latched at the taking edge since the inputs may move meanwhile
module cbsc_exec_props
  import cbsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request
  input wire logic start,
  input wire cbsc_op_t opSel,
  input wire logic [15:0] immWord,
  input wire logic areaSlow,
  input wire logic [15:0] bcPair,
  input wire logic busy,
  input wire logic done,
  // write port and memory
  input wire logic regWrEn,
  input wire logic [1:0] regWrMask,
  input wire logic [15:0] regWrData,
  input wire logic memRe,
  input wire logic [15:0] memAddr,
  // cpu state
  input wire logic [15:0] pc,
  input wire logic [15:0] sp,
  input wire logic [7:0] programStatusWord,
  input wire logic haltMode,
  input wire logic stopMode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  logic take;
  cbsc_op_t curOp;
  logic [15:0] curPc, curSp, curImm, rel;
  logic [7:0] curPsw, curB;
  logic curSlow;
  logic [3:0] cnt;
  assign take = start && !busy && !haltMode && !stopMode;
  assign rel = {{8{curImm[7]}}, curImm[7:0]};

  // cnt equals the cycle index inside the running instruction
  always_ff @(posedge clk) begin
    if (take) begin
      curOp <= opSel;
      curPc <= pc;
      curSp <= sp;
      curImm <= immWord;
      curPsw <= programStatusWord;
      curB <= bcPair[15:8];
      curSlow <= areaSlow;
      cnt <= 4'h0;
    end else if (busy) begin
      cnt <= cnt + 4'h1;
    end
  end

  // low byte read first, high byte on the next cycle
  sequence pop_reads;
    memRe && memAddr == curSp ##1 memRe && memAddr == curSp + 16'h0001;
  endsequence
  sequence pop_finish;
    ##2 done && regWrEn && regWrMask == 2'h3;
  endsequence

  pop_read_order_a: assert property (
    take && opSel == OP_POP_PAIR |=> pop_reads ##0 pop_finish)
    else $error("pair pop access order wrong");
  pop_sp_step_a: assert property (
    done && curOp == OP_POP_PAIR |=> sp == curSp + 16'h0002)
    else $error("stack pointer not advanced by two");
  jump_target_a: assert property (
    done && curOp == OP_JUMP_ALWAYS |=> pc == curPc + 16'h0002 + rel)
    else $error("relative jump target wrong");
  carry_jump_a: assert property (done && curOp == OP_JUMP_IF_CARRY |=>
    pc == curPc + 16'h0002 + (curPsw[PSW_CARRY] ? rel : 16'h0000))
    else $error("carry jump decision wrong");
  nonzero_jump_a: assert property (done && curOp == OP_JUMP_IF_NONZERO |=>
    pc == curPc + 16'h0002 + (curPsw[PSW_ZERO] ? 16'h0000 : rel))
    else $error("nonzero jump decision wrong");
  six_clocks_a: assert property (done && curOp inside {OP_JUMP_ALWAYS,
    OP_JUMP_IF_CARRY, OP_JUMP_IF_ZERO, OP_DEC_JUMP_B, OP_IRQ_ENABLE, OP_IRQ_DISABLE} |->
    cnt == 4'h5)
    else $error("six clock instruction took another count");
  dec_mem_clk_a: assert property (done && curOp == OP_DEC_JUMP_MEM |->
    cnt == (curSlow ? 4'h9 : 4'h7))
    else $error("memory decrement clock count wrong");
  loop_dec_a: assert property (done && curOp == OP_DEC_JUMP_B |->
    regWrEn && regWrData[15:8] == curB - 8'h01)
    else $error("loop register not decremented");
  irq_flag_a: assert property (
    done && curOp inside {OP_IRQ_ENABLE, OP_IRQ_DISABLE} |=>
    programStatusWord[PSW_IE] == (curOp == OP_IRQ_ENABLE))
    else $error("interrupt enable flag wrong");
  bank_bits_a: assert property (
    done && curOp == OP_BANK_SELECT |=> programStatusWord[PSW_BANK1] == curImm[1]
    && programStatusWord[PSW_BANK0] == curImm[0])
    else $error("bank bits wrong");
  standby_entry_a: assert property (done && curOp == OP_HALT |=> haltMode && !busy)
    else $error("halt mode not entered");
endmodule // cbsc_exec_props

bind cbsc_exec cbsc_exec_props u_props (.clk(clk), .rst(rst), .start(start), .opSel(opSel),
  .immWord(immWord), .areaSlow(areaSlow), .bcPair(bcPair), .busy(busy), .done(done),
  .regWrEn(regWrEn), .regWrMask(regWrMask), .regWrData(regWrData), .memRe(memRe),
  .memAddr(memAddr), .pc(pc), .sp(sp), .programStatusWord(programStatusWord),
  .haltMode(haltMode), .stopMode(stopMode));

// ---- verification/cbsc_mem_model.sv ----
// Purpose: data memory beside the unit, 256 bytes
// Assumes: read data is due the cycle after the read strobe
// Notes: outside a read answer the bus toggles, so stale data never looks valid
module cbsc_mem_model (
  // clock
  input wire logic clk,
  // access
  input wire logic memRe,
  input wire logic memWe,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWrData,
  output logic [7:0] memRdData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] store [256];

  // one cycle read latency, write on the strobe edge
  // plain always: the bench preloads store directly, so it has a second writer
  always @(posedge clk) begin
    if (memWe) begin
      store[memAddr[7:0]] <= memWrData;
    end
    memRdData <= memRe ? store[memAddr[7:0]] : ~memRdData;
  end
endmodule // cbsc_mem_model

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench for the branch and stack control unit
// Assumes: 50 ns clock, reset held 20 cycles
// Notes: expected program counters are rebuilt from length and offset
module tb_top
  import cbsc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, start, areaSlow, wakePin, busy, done, regWrEn, memRe, memWe;
  logic haltMode, stopMode, lastEn;
  cbsc_op_t opSel;
  cbsc_bit_kind_t bitKind;
  logic [2:0] bitSel;
  logic [1:0] pairSel, regWrPair, regWrMask, lastPair;
  logic [15:0] opAddr, immWord, accPair, bcPair, hlPair, regWrData, memAddr, pc, sp, lastWr;
  logic [7:0] memWrData, memRdData, programStatusWord;
  int failures, testsRun;

  // free running clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  cbsc_exec dut (.clk(clk), .rst(rst), .start(start), .opSel(opSel), .bitKind(bitKind),
    .bitSel(bitSel), .pairSel(pairSel), .opAddr(opAddr), .immWord(immWord),
    .areaSlow(areaSlow), .busy(busy), .done(done), .accPair(accPair), .bcPair(bcPair),
    .hlPair(hlPair), .regWrEn(regWrEn), .regWrPair(regWrPair), .regWrMask(regWrMask),
    .regWrData(regWrData), .memRe(memRe), .memWe(memWe), .memAddr(memAddr),
    .memWrData(memWrData), .memRdData(memRdData), .pc(pc), .sp(sp),
    .programStatusWord(programStatusWord), .haltMode(haltMode), .stopMode(stopMode),
    .wakePin(wakePin));
  cbsc_mem_model mem (.clk(clk), .memRe(memRe), .memWe(memWe), .memAddr(memAddr),
    .memWrData(memWrData), .memRdData(memRdData));

  task automatic chk(input logic ok, input string msg);
    testsRun++;
    if (ok !== 1'b1) begin
      failures++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask

  // issue one instruction, count its clocks and check the next program counter
  task automatic exec(input cbsc_op_t op, input int n, input int len, input logic taken,
      input logic [15:0] imm = 16'h0000, input cbsc_bit_kind_t kind = BIT_ACC,
      input logic [2:0] bsel = 3'h0, input logic [15:0] addr = 16'h0000,
      input logic slow = 1'b0, input logic absJump = 1'b0);
    logic [15:0] pc0, expPc;
    int k;
    pc0 = pc;
    @(posedge clk);
    opSel <= op;
    bitKind <= kind;
    bitSel <= bsel;
    opAddr <= addr;
    immWord <= imm;
    areaSlow <= slow;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    k = 0;
    @(negedge clk);
    while (done !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    lastWr = regWrData;
    lastEn = regWrEn;
    lastPair = regWrPair;
    chk(k == n - 1, "instruction clock count");
    @(posedge clk);
    #1;
    // absolute forms load the target whole, relative ones add the signed offset
    expPc = absJump ? ((op == OP_JUMP_ACC) ? accPair : imm)
                    : pc0 + 16'(len) + (taken ? {{8{imm[7]}}, imm[7:0]} : 16'h0000);
    chk(pc === expPc, "next pc");
  endtask

  task automatic t_jump();
    exec(OP_JUMP_ALWAYS, 6, 2, 1'b1, 16'h0080);
    exec(OP_JUMP_ALWAYS, 6, 2, 1'b1, 16'h007f);
    $display("relative jump test done");
  endtask

  task automatic t_cond(input logic cy, input logic z);
    exec(OP_JUMP_IF_CARRY, 6, 2, cy, 16'h00f0);
    exec(OP_JUMP_IF_NO_CARRY, 6, 2, !cy, 16'h0010);
    exec(OP_JUMP_IF_ZERO, 6, 2, z, 16'h00f8);
    exec(OP_JUMP_IF_NONZERO, 6, 2, !z, 16'h0020);
    $display("conditional jump test done");
  endtask

  task automatic t_stack();
    mem.store[8'h40] = 8'h34;
    mem.store[8'h41] = 8'h12;
    mem.store[8'h42] = 8'h41;
    exec(OP_SP_LOAD_IMM, 10, 4, 1'b0, 16'h0040);
    exec(OP_POP_PAIR, 4, 1, 1'b0);
    chk(lastEn === 1'b1 && lastWr === 16'h1234 && sp === 16'h0042, "pair pop");
    chk(lastPair === PAIR_DE, "pair pop target");
    exec(OP_POP_PSW, 2, 1, 1'b0);
    chk(programStatusWord === 8'h41 && sp === 16'h0043, "status pop");
    $display("stack test done");
  endtask

  task automatic t_bits();
    mem.store[8'h80] = 8'h08;
    mem.store[8'h90] = 8'h04;
    @(posedge clk) accPair <= 16'hdf00;
    exec(OP_JUMP_IF_BIT_SET, 8, 3, 1'b1, 16'h0020, BIT_SHORT_DIRECT, 3'h3, 16'h0080);
    exec(OP_JUMP_IF_BIT_SET, 9, 3, 1'b0, 16'h0020, BIT_SHORT_DIRECT, 3'h2, 16'h0080,
      1'b1);
    exec(OP_JUMP_IF_BIT_SET, 11, 4, 1'b1, 16'h0030, BIT_SFR, 3'h3, 16'h0080, 1'b1);
    exec(OP_JUMP_IF_BIT_CLEAR, 10, 4, 1'b0, 16'h0020, BIT_SHORT_DIRECT, 3'h3,
      16'h0080);
    exec(OP_JUMP_IF_BIT_CLEAR, 8, 3, 1'b1, 16'h00e0, BIT_ACC, 3'h5);
    exec(OP_JUMP_IF_BIT_CLEAR, 8, 3, 1'b0, 16'h00e0, BIT_ACC, 3'h4);
    exec(OP_JUMP_AND_CLEAR_BIT, 12, 3, 1'b1, 16'h0040, BIT_INDIRECT, 3'h2, , 1'b1);
    chk(mem.store[8'h90] === 8'h00, "indirect bit cleared");
    exec(OP_JUMP_AND_CLEAR_BIT, 10, 3, 1'b0, 16'h0040, BIT_INDIRECT, 3'h2);
    exec(OP_JUMP_AND_CLEAR_BIT, 12, 4, 1'b1, 16'h0008, BIT_PSW, 3'h0);
    chk(programStatusWord === 8'h40, "status bit cleared");
    $display("bit jump test done");
  endtask

  task automatic t_loop();
    mem.store[8'h50] = 8'h01;
    @(posedge clk) bcPair <= 16'h0200;
    exec(OP_DEC_JUMP_B, 6, 2, 1'b1, 16'h00fc);
    chk(lastEn === 1'b1 && lastWr[15:8] === 8'h01, "loop register");
    @(posedge clk) bcPair <= 16'h0100;
    exec(OP_DEC_JUMP_B, 6, 2, 1'b0, 16'h00fc);
    exec(OP_DEC_JUMP_MEM, 8, 3, 1'b0, 16'h0010, , , 16'h0050);
    chk(mem.store[8'h50] === 8'h00, "byte decremented");
    exec(OP_DEC_JUMP_MEM, 10, 3, 1'b1, 16'h0010, , , 16'h0050, 1'b1);
    chk(mem.store[8'h50] === 8'hff, "byte wrapped");
    $display("loop test done");
  endtask

  task automatic t_misc();
    @(posedge clk) accPair <= 16'h0123;
    exec(OP_SP_LOAD_ACC, 8, 2, 1'b0);
    chk(sp === 16'h0123, "stack pointer from pair");
    exec(OP_ACC_LOAD_SP, 8, 2, 1'b0);
    chk(lastEn === 1'b1 && lastPair === PAIR_ACC && lastWr === 16'h0123, "pair from sp");
    @(posedge clk) bcPair <= 16'h0002;
    exec(OP_DEC_JUMP_C, 6, 2, 1'b1, 16'h0004);
    chk(lastEn === 1'b1 && lastPair === PAIR_BC && lastWr[7:0] === 8'h01, "low loop");
    exec(OP_JUMP_ABS, 6, 3, 1'b0, 16'h0200, , , , , 1'b1);
    exec(OP_JUMP_ACC, 8, 2, 1'b0, , , , , , 1'b1);
    $display("misc test done");
  endtask

  task automatic t_ctrl();
    logic [15:0] p;
    exec(OP_IRQ_ENABLE, 6, 2, 1'b0);
    chk(programStatusWord[PSW_IE] === 1'b1, "irq enabled");
    exec(OP_IRQ_DISABLE, 6, 2, 1'b0);
    chk(programStatusWord[PSW_IE] === 1'b0, "irq disabled");
    exec(OP_BANK_SELECT, 4, 2, 1'b0, 16'h0002);
    chk(programStatusWord[PSW_BANK1] === 1'b1
        && programStatusWord[PSW_BANK0] === 1'b0, "bank");
    exec(OP_NOP, 2, 1, 1'b0);
    exec(OP_HALT, 6, 2, 1'b0);
    p = pc;
    chk(haltMode === 1'b1, "halt entered");
    @(posedge clk) start <= 1'b1;
    repeat (3) @(posedge clk);
    start <= 1'b0;
    wakePin <= 1'b1;
    #1;
    chk(busy === 1'b0 && pc === p, "start refused in standby");
    repeat (4) @(posedge clk);
    wakePin <= 1'b0;
    exec(OP_STOP, 6, 2, 1'b0);
    chk(stopMode === 1'b1 && haltMode === 1'b0, "stop entered");
    $display("control test done");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    {rst, start, areaSlow, wakePin} = 4'h8;
    opSel = OP_NOP;
    bitKind = BIT_ACC;
    {bitSel, pairSel, opAddr, immWord} = '0;
    {accPair, bcPair, hlPair} = {16'h0000, 16'h0000, 16'h0090};
    pairSel = 2'h2;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_jump();
    t_cond(1'b0, 1'b0);
    t_stack();
    t_cond(1'b1, 1'b1);
    t_bits();
    t_loop();
    t_misc();
    t_ctrl();
    give_verdict();
  end

  // hang guard, several times the expected run
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    give_verdict();
  end
endmodule // tb_top
